// [pkg/cpp_defines.vh]
// Constants of the CAN pin port control block.
// Included by the port control design file; definitions only.
`ifndef CPP_DEFINES_VH
`define CPP_DEFINES_VH
// Register byte addresses
`define CPP_ADDR_MON 12'h000
`define CPP_ADDR_MSTOP 12'h004
`define CPP_ADDR_MCTL 12'h008
`define CPP_ADDR_GSTAT 12'h00c
`define CPP_ADDR_IREQ 12'h010
`define CPP_ADDR_IMASK 12'h014
`define CPP_ADDR_CTRL 12'h018
`define CPP_ADDR_MBOX_LO 12'h100
`define CPP_ADDR_MBOX_HI 12'h1fc
// Monitor register fields
`define CPP_MON_FORCE_BIT 6
`define CPP_MON_PINEN_BIT 5
`define CPP_MON_TXLVL_BIT 1
`define CPP_MON_RXLVL_BIT 0
`define CPP_MON_WMASK 8'h60
// Master control register
`define CPP_MCTL_SRST_BIT 0
`define CPP_MCTL_SLEEP_BIT 5
`define CPP_MCTL_HALT_BIT 1
// Interrupt bits
`define CPP_IRQ_RESET_BIT 0
`define CPP_IRQ_MBOXRX_BIT 1
`define CPP_IRQ_WIDTH 2
// Reset values
`define CPP_MSTOP_RST 1'b1
`define CPP_IREQ_RST 2'h1
`define CPP_IMASK_RST 2'h0
// Mailbox wait window while a frame is stored
`define CPP_MBOX_WAIT_MAX 3'h5
`define CPP_MBOX_WORDS 64
`endif

// [rtl/cpp_sync2.v]
// Two-flop level synchroniser.
// Assumes one clock and an asynchronous active-high reset.
`timescale 1ns/1ps
module cpp_sync2
(
	clk,
	sys_rst,
	din,
	dout
);
input wire clk;
input wire sys_rst;
input wire din;
output reg dout;
reg meta_ff;

// =====================================================
// Synchroniser
always @(posedge clk or posedge sys_rst)
begin
	if (sys_rst)
	begin
		meta_ff <= 1'b1;
		dout <= 1'b1;
	end
	else
	begin
		meta_ff <= din;
		dout <= meta_ff;
	end
end
endmodule // cpp_sync2

// [rtl/cpp_port_ctrl.v]
// CAN pin port control: monitor register, module stop, resets, sleep access, mailbox waits.
// Assumes an APB master on clk and an external transceiver on the CAN pins.
// Operation
// R01: Force bit high drives the transmit pin high regardless of controller data.
// R02: Pins connect to the controller only while the pin-enable bit is one.
// R03: Bit 1 reads the transmit pin level; writes ignored.
// R04: Bit 0 reads the receive pin level; writes ignored.
// R05: Monitor register survives module stop, sleep and soft reset.
// R06: Software writes zero to reserved bits 7 and 4..2; they reset zero.
// R07: Controller clock gated after reset; release module stop before other registers.
// R08: Controller reinitialised by power-on reset and module stop.
// R09: Soft reset bit reinitialises all registers but the master control one; code also keeps the monitor and module stop registers.
// R10: Any reset sets the reset-transition flag; software clears it.
// R11: Mailbox RAM not cleared by reset; software initialises it.
// R12: In sleep only master control, status, request and mask are accessible; code also admits the monitor and module stop registers.
// R13: Mailbox access during frame storage stretched by zero to five waits.
// R14: DMA reads mailbox 0 through its first control field in block mode.
// R15: Interrupt service reads the flag back after clearing it.
// R16: Reset, halt or sleep entry raises the reset flag; maskable.
// R17: Pin levels synchronised to the clock before being read.
`timescale 1ns/1ps
`include "cpp_defines.vh"
module cpp_port_ctrl
(
	clk,
	sys_rst,
	psel,
	penable,
	pwrite,
	paddr,
	pwdata,
	prdata,
	pready,
	pslverr,
	ctl_tx_data,
	ctl_rx_data,
	ctl_frame_store,
	ctl_clk_en,
	ctl_soft_rst,
	can_transmit_pin,
	can_receive_pin,
	irq
);
input wire clk;
input wire sys_rst;
input wire psel;
input wire penable;
input wire pwrite;
input wire [11:0] paddr;
input wire [31:0] pwdata;
output reg [31:0] prdata;
output reg pready;
output reg pslverr;
input wire ctl_tx_data;
output reg ctl_rx_data;
input wire ctl_frame_store;
output reg ctl_clk_en;
output reg ctl_soft_rst;
output reg can_transmit_pin;
input wire can_receive_pin;
output reg irq;

localparam ST_IDLE = 3'b001;
localparam ST_WAIT = 3'b010;
localparam ST_DONE = 3'b100;

reg transmit_force_high_ff;
reg can_pin_enable_ff;
reg mstop_ff;
reg halt_ff;
reg sleep_ff;
reg srst_ff;
reg [`CPP_IRQ_WIDTH-1:0] ireq_ff;
reg [`CPP_IRQ_WIDTH-1:0] imask_ff;
reg [2:0] state_ff;
reg [2:0] wait_ff;
reg store_d_ff;
reg [31:0] mbox_mem [0:`CPP_MBOX_WORDS-1];
wire transmit_pin_level;
wire receive_pin_level;
wire is_mon;
wire is_mbox;
wire sleep_ok;
wire ctl_off;
wire allowed;
wire mapped;
wire setup;
wire wr_go;
wire rd_go;
wire [5:0] mbox_idx;
wire enter_state;
reg [31:0] nxt_rdata;
reg [`CPP_IRQ_WIDTH-1:0] nxt_ireq;

// =====================================================
// Pin level synchronisers
cpp_sync2 u_sync_tx
(
	.clk(clk),
	.sys_rst(sys_rst),
	.din(can_transmit_pin),
	.dout(transmit_pin_level)
); // R17
cpp_sync2 u_sync_rx
(
	.clk(clk),
	.sys_rst(sys_rst),
	.din(can_receive_pin),
	.dout(receive_pin_level)
); // R17

// =====================================================
// Address decode
assign is_mon = (paddr == `CPP_ADDR_MON) || (paddr == `CPP_ADDR_MSTOP);
assign is_mbox = (paddr >= `CPP_ADDR_MBOX_LO) && (paddr <= `CPP_ADDR_MBOX_HI);
assign sleep_ok = (paddr == `CPP_ADDR_MCTL) || (paddr == `CPP_ADDR_GSTAT) ||
	(paddr == `CPP_ADDR_IREQ) || (paddr == `CPP_ADDR_IMASK); // R12
assign ctl_off = mstop_ff || srst_ff;
assign mapped = is_mon || is_mbox || sleep_ok || (paddr == `CPP_ADDR_CTRL);
assign allowed = is_mon || (!mstop_ff && (!sleep_ff || sleep_ok)); // R07 R12
assign mbox_idx = paddr[7:2];
assign setup = psel && !penable && (state_ff == ST_IDLE);
assign wr_go = (state_ff == ST_DONE) && pwrite && allowed && mapped;
assign rd_go = (state_ff == ST_DONE) && !pwrite;
assign enter_state = (pwdata[`CPP_MCTL_HALT_BIT] && !halt_ff) ||
	(pwdata[`CPP_MCTL_SLEEP_BIT] && !sleep_ff);

// =====================================================
// Access sequencer with mailbox wait
always @(posedge clk or posedge sys_rst)
begin
	if (sys_rst)
	begin
		state_ff <= ST_IDLE;
		wait_ff <= 3'h0;
		pready <= 1'b0;
		pslverr <= 1'b0;
	end
	else
	begin
		pready <= 1'b0;
		pslverr <= 1'b0;
		case (state_ff)
			ST_IDLE:
			begin
				if (setup)
				begin
					wait_ff <= (is_mbox && ctl_frame_store) ? `CPP_MBOX_WAIT_MAX : 3'h0; // R13
					state_ff <= ST_WAIT;
				end
			end
			ST_WAIT:
			begin
				if (wait_ff != 3'h0 && (store_d_ff || ctl_frame_store))
					wait_ff <= wait_ff - 3'h1; // R13
				else
				begin
					state_ff <= ST_DONE;
					pready <= 1'b1;
					pslverr <= !(mapped && allowed);
				end
			end
			ST_DONE:
			begin
				state_ff <= ST_IDLE;
			end
			default:
			begin
				state_ff <= ST_IDLE;
			end
		endcase
	end
end

// =====================================================
// Monitor register, kept over module stop, sleep and soft reset
always @(posedge clk or posedge sys_rst)
begin
	if (sys_rst)
	begin
		transmit_force_high_ff <= 1'b0;
		can_pin_enable_ff <= 1'b0;
	end
	else if (wr_go && paddr == `CPP_ADDR_MON)
	begin
		transmit_force_high_ff <= pwdata[`CPP_MON_FORCE_BIT]; // R05 R06
		can_pin_enable_ff <= pwdata[`CPP_MON_PINEN_BIT]; // R03 R04
	end
end

// =====================================================
// Module stop and controller registers
always @(posedge clk or posedge sys_rst)
begin
	if (sys_rst)
	begin
		mstop_ff <= `CPP_MSTOP_RST; // R07
		halt_ff <= 1'b0;
		sleep_ff <= 1'b0;
		srst_ff <= 1'b0;
		imask_ff <= `CPP_IMASK_RST;
		ireq_ff <= `CPP_IREQ_RST; // R10
		store_d_ff <= 1'b0;
	end
	else
	begin
		store_d_ff <= ctl_frame_store;
		ireq_ff <= nxt_ireq;
		if (wr_go && paddr == `CPP_ADDR_MSTOP)
			mstop_ff <= pwdata[0];
		if (mstop_ff || (wr_go && paddr == `CPP_ADDR_MSTOP && pwdata[0]))
		begin
			halt_ff <= 1'b0; // R08
			sleep_ff <= 1'b0;
			srst_ff <= 1'b0;
			imask_ff <= `CPP_IMASK_RST;
		end
		else if (wr_go && paddr == `CPP_ADDR_MCTL)
		begin
			halt_ff <= pwdata[`CPP_MCTL_HALT_BIT];
			sleep_ff <= pwdata[`CPP_MCTL_SLEEP_BIT];
			srst_ff <= pwdata[`CPP_MCTL_SRST_BIT];
		end
		else if (srst_ff)
			imask_ff <= `CPP_IMASK_RST; // R09
		else if (wr_go && paddr == `CPP_ADDR_IMASK)
			imask_ff <= pwdata[`CPP_IRQ_WIDTH-1:0];
	end
end

// =====================================================
// Interrupt flags: set wins over read clear, reset over all
always @*
begin
	nxt_ireq = ireq_ff;
	if (rd_go && allowed && paddr == `CPP_ADDR_IREQ)
		nxt_ireq = {`CPP_IRQ_WIDTH{1'b0}}; // R15
	if (wr_go && paddr == `CPP_ADDR_MCTL && enter_state)
		nxt_ireq[`CPP_IRQ_RESET_BIT] = 1'b1; // R16
	if (store_d_ff && !ctl_frame_store)
		nxt_ireq[`CPP_IRQ_MBOXRX_BIT] = 1'b1;
	if (ctl_off)
		nxt_ireq = `CPP_IREQ_RST; // R08 R09 R10 R16
end

// =====================================================
// Mailbox RAM, never cleared by reset
always @(posedge clk)
begin
	if (wr_go && is_mbox)
		mbox_mem[mbox_idx] <= pwdata; // R11
end

// =====================================================
// Read data
always @*
begin
	nxt_rdata = 32'h0000_0000;
	if (allowed)
	begin
		if (paddr == `CPP_ADDR_MON)
			nxt_rdata = {24'h000000, 1'b0, transmit_force_high_ff, can_pin_enable_ff, 3'h0,
				transmit_pin_level, receive_pin_level}; // R03 R04 R06
		else if (paddr == `CPP_ADDR_MSTOP)
			nxt_rdata = {31'h0000_0000, mstop_ff};
		else if (paddr == `CPP_ADDR_MCTL)
			nxt_rdata = {26'h000_0000, sleep_ff, 3'h0, halt_ff, srst_ff};
		else if (paddr == `CPP_ADDR_GSTAT)
			nxt_rdata = {29'h0000_0000, sleep_ff, halt_ff, mstop_ff};
		else if (paddr == `CPP_ADDR_IREQ)
			nxt_rdata = {30'h0000_0000, ireq_ff};
		else if (paddr == `CPP_ADDR_IMASK)
			nxt_rdata = {30'h0000_0000, imask_ff};
		else if (is_mbox)
			nxt_rdata = mbox_mem[mbox_idx];
	end
end

// =====================================================
// Outputs and pin mux
always @(posedge clk or posedge sys_rst)
begin
	if (sys_rst)
	begin
		prdata <= 32'h0000_0000;
		can_transmit_pin <= 1'b1;
		ctl_rx_data <= 1'b1;
		ctl_clk_en <= 1'b0;
		ctl_soft_rst <= 1'b1;
		irq <= 1'b0;
	end
	else
	begin
		if (state_ff == ST_WAIT)
			prdata <= nxt_rdata;
		can_transmit_pin <= transmit_force_high_ff || !can_pin_enable_ff || ctl_tx_data; // R01 R02
		ctl_rx_data <= can_pin_enable_ff ? receive_pin_level : 1'b1; // R02
		ctl_clk_en <= !mstop_ff && !sleep_ff; // R07 R12
		ctl_soft_rst <= ctl_off; // R08 R09
		irq <= |(ireq_ff & ~imask_ff); // R16
	end
end
endmodule // cpp_port_ctrl

// [verification/cpp_port_ctrl_assertions.sv]
// Port checker for the CAN pin port control block.
// Assumes one clock and the block's own APB timing.
`timescale 1ns/1ps
module cpp_port_ctrl_assertions
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic ctl_tx_data,
	input wire logic ctl_rx_data,
	input wire logic ctl_frame_store,
	input wire logic ctl_clk_en,
	input wire logic ctl_soft_rst,
	input wire logic can_transmit_pin,
	input wire logic can_receive_pin,
	input wire logic irq
);
	// ====
	// Shadow of monitor and stop bits
	logic frc_ff, pen_ff, mst_ff;
	logic [1:0] age_ff;
	wire wr = psel && penable && pready && !pslverr && pwrite;
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			frc_ff <= 1'b0;
			pen_ff <= 1'b0;
			mst_ff <= 1'b1;
			age_ff <= 2'h3;
		end
		else
		begin
			if (wr && paddr == 12'h000)
			begin
				frc_ff <= pwdata[6];
				pen_ff <= pwdata[5];
			end
			if (wr && paddr == 12'h004)
				mst_ff <= pwdata[0];
			age_ff <= (wr && paddr == 12'h000) ? 2'h0 : age_ff + {1'b0, age_ff != 2'h3};
		end
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);
	sequence setup_s;
		psel && !penable ##1 psel && penable;
	endsequence
	// ====
	// Checks
	chk_ready_bound: assert property (setup_s |-> ##[1:6] pready)
		else $error("pready late");
	chk_ready_pulse: assert property (pready |=> !pready)
		else $error("pready too long");
	chk_err_ready: assert property (pslverr |-> pready)
		else $error("pslverr alone");
	chk_force_high: assert property (age_ff == 2'h3 && frc_ff |-> can_transmit_pin)
		else $error("tx not forced");
	chk_pins_off: assert property (age_ff == 2'h3 && !pen_ff |-> can_transmit_pin && ctl_rx_data)
		else $error("pins not cut off");
	chk_pin_follow: assert property (age_ff == 2'h3 && pen_ff && !frc_ff |-> can_transmit_pin == $past(ctl_tx_data))
		else $error("tx pin not following");
	chk_mon_bits: assert property (pready && !pwrite && paddr == 12'h000 |-> prdata[7:2] == {1'b0, frc_ff, pen_ff, 3'h0})
		else $error("monitor bits wrong");
	chk_stop_refuse: assert property (pready && mst_ff && paddr > 12'h004 |-> pslverr)
		else $error("access in module stop");
	chk_stop_gate: assert property (mst_ff && $past(mst_ff) |-> ctl_soft_rst && !ctl_clk_en)
		else $error("clock not gated");
	chk_irq_reset: assert property ($fell(sys_rst) |-> ##[0:2] irq)
		else $error("no irq after reset");
endmodule // cpp_port_ctrl_assertions
bind cpp_port_ctrl cpp_port_ctrl_assertions i_chk (.clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata,
	.prdata, .pready, .pslverr, .ctl_tx_data, .ctl_rx_data, .ctl_frame_store, .ctl_clk_en, .ctl_soft_rst,
	.can_transmit_pin, .can_receive_pin, .irq);

// [verification/cpp_can_bus_model.sv]
// CAN bus behind a transceiver: wired-AND with one other node.
// Assumes clk as time base for the loop delay.
`timescale 1ns/1ps
module cpp_can_bus_model
(
	input wire logic clk,
	input wire logic tx_pin,
	input wire logic other_dominant,
	output logic rx_pin
);
	// Recessive unless a node is dominant
	always @(posedge clk)
		rx_pin <= tx_pin & ~other_dominant;
endmodule // cpp_can_bus_model

// [verification/tb_can_pin_port_control.sv]
// Testbench of the CAN pin port control block.
// Assumes the design, bus model and checker are compiled first.
`timescale 1ns/1ps
module tb_can_pin_port_control;
	logic clk, sys_rst, psel, penable, pwrite, ctl_tx_data, ctl_frame_store, dom, er;
	logic [11:0] paddr;
	logic [31:0] pwdata, rd;
	wire [31:0] prdata;
	wire pready, pslverr, ctl_rx_data, ctl_clk_en, ctl_soft_rst, can_transmit_pin, can_receive_pin, irq;
	integer n_errors = 0;
	integer tests_run = 0;
	cpp_port_ctrl i_cpp_port_ctrl (.clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .ctl_tx_data, .ctl_rx_data, .ctl_frame_store, .ctl_clk_en, .ctl_soft_rst,
		.can_transmit_pin, .can_receive_pin, .irq);
	cpp_can_bus_model i_cpp_can_bus_model (.clk, .tx_pin(can_transmit_pin), .other_dominant(dom),
		.rx_pin(can_receive_pin));
	// ====
	// Tasks
	task complete_run;
		begin
			if (n_errors == 0 && tests_run > 0)
				$display("Run complete: PASS");
			else
				$display("Run complete: FAIL");
			$finish;
		end
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		begin
			tests_run++;
			if (g !== e)
			begin
				n_errors++;
				$display("wrong value at %0t: got %h expected %h", $time, g, e);
			end
		end
	endtask
	task ac(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] e, input logic ee);
		begin
			@(posedge clk);
			psel <= 1'b1;
			pwrite <= w;
			paddr <= a;
			pwdata <= d;
			@(posedge clk);
			penable <= 1'b1;
			@(posedge clk);
			while (pready !== 1'b1)
				@(posedge clk);
			rd = prdata;
			er = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
			chk({31'h0, er}, {31'h0, ee});
			if (!w)
				chk(rd, e);
		end
	endtask
	task mon(input logic [31:0] d, input logic [31:0] e);
		begin
			ac(1'b1, 12'h000, d, 32'h0, 1'b0);
			repeat (8)
				@(posedge clk);
			ac(1'b0, 12'h000, 32'h0, e, 1'b0);
		end
	endtask
	// ====
	// Clock, timeout, sequence
	initial
	begin
		clk = 1'b0;
		forever
			#2 clk = ~clk;
	end
	initial
	begin
		repeat (3000)
			@(posedge clk);
		n_errors++;
		complete_run();
	end
	initial
	begin
		{sys_rst, ctl_tx_data} = 2'h3;
		{psel, penable, pwrite, ctl_frame_store, dom, paddr, pwdata} = '0;
		repeat (8)
			@(posedge clk);
		sys_rst <= 1'b0;
		repeat (3)
			@(negedge clk);
		chk({31'h0, irq}, 32'h1);
		mon(32'h0, 32'h3);
		ac(1'b0, 12'h008, 32'h0, 32'h0, 1'b1);
		ac(1'b0, 12'h100, 32'h0, 32'h0, 1'b1);
		chk({30'h0, ctl_clk_en, ctl_soft_rst}, 32'h1);
		mon(32'h43, 32'h43);
		ctl_tx_data <= 1'b0;
		mon(32'h60, 32'h63);
		mon(32'h20, 32'h20);
		repeat (3)
			@(negedge clk);
		chk({30'h0, can_transmit_pin, ctl_rx_data}, 32'h0);
		@(posedge clk);
		ctl_tx_data <= 1'b1;
		dom <= 1'b1;
		mon(32'h20, 32'h22);
		ac(1'b1, 12'h004, 32'h0, 32'h0, 1'b0);
		repeat (3)
			@(negedge clk);
		chk({30'h0, ctl_clk_en, ctl_soft_rst}, 32'h2);
		ac(1'b0, 12'h010, 32'h0, 32'h1, 1'b0);
		ac(1'b0, 12'h010, 32'h0, 32'h0, 1'b0);
		repeat (3)
			@(negedge clk);
		chk({31'h0, irq}, 32'h0);
		ac(1'b1, 12'h014, 32'h3, 32'h0, 1'b0);
		ac(1'b1, 12'h008, 32'h1, 32'h0, 1'b0);
		ac(1'b1, 12'h008, 32'h0, 32'h0, 1'b0);
		ac(1'b0, 12'h014, 32'h0, 32'h0, 1'b0);
		ac(1'b0, 12'h000, 32'h0, 32'h22, 1'b0);
		ac(1'b0, 12'h010, 32'h0, 32'h1, 1'b0);
		ac(1'b1, 12'h014, 32'h1, 32'h0, 1'b0);
		ac(1'b1, 12'h008, 32'h2, 32'h0, 1'b0);
		repeat (3)
			@(negedge clk);
		chk({31'h0, irq}, 32'h0);
		ac(1'b0, 12'h010, 32'h0, 32'h1, 1'b0);
		ac(1'b1, 12'h008, 32'h20, 32'h0, 1'b0);
		ac(1'b0, 12'h018, 32'h0, 32'h0, 1'b1);
		ac(1'b0, 12'h00c, 32'h0, 32'h4, 1'b0);
		ac(1'b0, 12'h000, 32'h0, 32'h22, 1'b0);
		ac(1'b1, 12'h008, 32'h0, 32'h0, 1'b0);
		ac(1'b1, 12'h100, 32'h5a3c, 32'h0, 1'b0);
		ctl_frame_store <= 1'b1;
		ac(1'b0, 12'h100, 32'h0, 32'h5a3c, 1'b0);
		ctl_frame_store <= 1'b0;
		ac(1'b0, 12'h010, 32'h0, 32'h3, 1'b0);
		ac(1'b0, 12'h200, 32'h0, 32'h0, 1'b1);
		complete_run();
	end
endmodule // tb_can_pin_port_control
